// [hdl/pcg_pkg.sv]
// Package of constants for the peripheral clock gating block
package pcg_pkg;
    // Register byte addresses
    localparam logic [11:0] PCG_ADDR_GATE = 12'h000;
    localparam logic [11:0] PCG_ADDR_COMP = 12'h004;
    localparam logic [11:0] PCG_ADDR_MCU = 12'h008;
    localparam logic [11:0] PCG_ADDR_DIS_LO = 12'h00C;
    localparam logic [11:0] PCG_ADDR_DIS_HI = 12'h010;
    localparam logic [11:0] PCG_ADDR_STATUS = 12'h014;
    localparam logic [11:0] PCG_ADDR_SLEEP = 12'h018;
    // Gate register fields
    localparam int PCG_BIT_CONV = 0;
    localparam int PCG_BIT_USART = 1;
    localparam int PCG_BIT_SPI = 2;
    localparam int PCG_BIT_TIMER = 3;
    localparam logic [3:0] PCG_GATE_RESET = 4'h0;
    // Comparator control fields
    localparam int PCG_BIT_CMP_DIS = 0;
    localparam int PCG_BIT_CMP_REF = 1;
    localparam int PCG_BIT_CMP_MUX = 2;
    localparam logic [2:0] PCG_COMP_RESET = 3'h0;
    // MCU control field
    localparam int PCG_BIT_IF_DIS = 0;
    // Other resets
    localparam logic [7:0] PCG_DIS_RESET = 8'h00;
    // Reference start-up time and its cycle count
    localparam int PCG_CLK_MHZ = 100;
    localparam int PCG_REF_START_US = 70;
    localparam int PCG_REF_START_CYC = PCG_REF_START_US * PCG_CLK_MHZ;
    // Sleep modes
    typedef enum logic [2:0] {
        PCG_SLP_ACTIVE = 3'b000,
        PCG_SLP_IDLE = 3'b001,
        PCG_SLP_NOISE = 3'b010,
        PCG_SLP_DOWN = 3'b011,
        PCG_SLP_SAVE = 3'b100,
        PCG_SLP_STANDBY = 3'b101
    } pcg_sleep_type;
endpackage

// [hdl/pcg_ref_timer.sv]
// Start-up timer of the internal voltage reference
`timescale 1ns/1ps
module pcg_ref_timer
    import pcg_pkg::*;
#(
    parameter int START_CYC = PCG_REF_START_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Reference demand
    input wire logic i_enable,
    // Ready
    output logic o_ready
);
    // A zero count would run the counter through its whole 32-bit range before leaving the counting branch
    if (START_CYC < 1) begin : g_bad_start
        $error("START_CYC must be at least 1");
    end
    typedef struct packed {
        logic [31:0] count;
        logic ready;
    } pcg_rt_type;
    pcg_rt_type state_reg;
    pcg_rt_type state_next;
    always_comb begin
        state_next = state_reg;
        if (!i_enable) begin
            state_next.count = 32'h00000000;
            state_next.ready = 1'b0;
        end else if (!state_reg.ready) begin
            // Kept on through sleep means no restart here
            if (state_reg.count == 32'(START_CYC - 1)) begin
                state_next.ready = 1'b1;
            end else begin
                state_next.count = state_reg.count + 32'h00000001;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign o_ready = state_reg.ready;
endmodule // pcg_ref_timer

// [hdl/pcg_clock_enable.sv]
// Per-peripheral clock enable with sleep-mode qualification
`timescale 1ns/1ps
module pcg_clock_enable
    import pcg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Controls
    input wire logic i_gate,
    input wire logic i_domain_run,
    // Enable
    output logic o_enable
);
    typedef struct packed {
        logic en;
    } pcg_ce_type;
    pcg_ce_type state_reg;
    pcg_ce_type state_next;
    always_comb begin
        state_next = state_reg;
        // Enable only, never a reset: the peripheral keeps its state
        state_next.en = i_domain_run && !i_gate;
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg.en <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end
    assign o_enable = state_reg.en;
endmodule // pcg_clock_enable

// [hdl/pcg_top.sv]
// Peripheral clock gating and sleep power control, APB slave
`timescale 1ns/1ps
// Operation
// - Gate register bits 7..4 read zero
// - Timer gate bit stops wide timer
// - SPI gate bit stops SPI clock
// - USART gate bit stops USART clock
// - Converter gate stops ADC, blocks comparator mux
// - Gated peripheral frozen, registers unreachable
// - Ungating resumes peripheral in same state
// - Gating matters in active and idle, converter gate also in noise
// - ADC stays on in sleep; restart extended
// - Comparator off in deep sleep; reference kept
// - Reference on when detector, comparator, ADC
// - Kept reference valid; re-enable needs startup
// - Fused brown-out detector active in sleep
// - Enabled watchdog runs in all sleep
// - Input buffers off when io, adc stopped
// - Low disable register bit kills pin buffer; high disable register has no effect
// - Debug fuse keeps main clock in deep sleep while interface enabled
// - Disable bit or fuse turns interface off
// - TDO undriven while TAP not shifting
module pcg_top
    import pcg_pkg::*;
#(
    parameter int REF_START_CYC = PCG_REF_START_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Fuses and peripheral status
    input wire logic [1:0] i_brownout_level_fuse,
    input wire logic i_debug_enable_fuse,
    input wire logic i_interface_enable_fuse,
    input wire logic i_adc_enable,
    input wire logic i_watchdog_enable,
    input wire logic [7:0] i_wake_pin_mask,
    // Test port
    input wire logic i_tap_shifting,
    input wire logic i_tdo_data,
    // Peripheral clock enables
    output logic o_timer_clk_en,
    output logic o_spi_clk_en,
    output logic o_usart_clk_en,
    output logic o_adc_clk_en,
    // Peripheral register access enables
    output logic [3:0] o_periph_access_en,
    // Analog controls
    output logic o_adc_extended_conv,
    output logic o_comparator_en,
    output logic o_comparator_mux_en,
    output logic o_reference_en,
    output logic o_reference_ready,
    output logic o_brownout_en,
    output logic o_watchdog_run,
    output logic [7:0] o_input_buffer_en,
    // Clock source and test port
    output logic o_main_clock_en,
    output logic o_interface_en,
    output logic o_tdo,
    output logic o_tdo_oe
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic deep_sleep(input logic [2:0] m);
        deep_sleep = (m == PCG_SLP_DOWN) || (m == PCG_SLP_SAVE) ||
                     (m == PCG_SLP_STANDBY);
    endfunction

    typedef struct packed {
        logic [3:0] gate;
        logic [2:0] comp;
        logic if_dis;
        logic [7:0] dis_lo;
        logic [7:0] dis_hi;
        logic [2:0] sleep;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic adc_prev;
        logic adc_ext;
        logic cmp_en;
        logic cmp_mux;
        logic ref_en;
        logic bod_en;
        logic wdt_run;
        logic [7:0] ibuf;
        logic main_clk;
        logic if_en;
        logic tdo;
        logic tdo_oe;
    } pcg_state_type;

    pcg_state_type state_reg;
    pcg_state_type state_next;
    logic periph_run;
    logic [3:0] clk_en;
    logic ref_ready;
    logic ref_demand;

    ////////////////////////////////////////////////////////////////////////
    // Gating acts in active and idle, converter also in noise; deeper modes stop these clocks anyway
    assign periph_run = (state_reg.sleep == PCG_SLP_ACTIVE) ||
                        (state_reg.sleep == PCG_SLP_IDLE);

    pcg_clock_enable u_ce_conv (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_gate(state_reg.gate[PCG_BIT_CONV]),
        .i_domain_run(periph_run || (state_reg.sleep == PCG_SLP_NOISE)),
        .o_enable(clk_en[PCG_BIT_CONV])
    );
    pcg_clock_enable u_ce_usart (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_gate(state_reg.gate[PCG_BIT_USART]),
        .i_domain_run(periph_run),
        .o_enable(clk_en[PCG_BIT_USART])
    );
    pcg_clock_enable u_ce_spi (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_gate(state_reg.gate[PCG_BIT_SPI]),
        .i_domain_run(periph_run),
        .o_enable(clk_en[PCG_BIT_SPI])
    );
    pcg_clock_enable u_ce_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_gate(state_reg.gate[PCG_BIT_TIMER]),
        .i_domain_run(periph_run),
        .o_enable(clk_en[PCG_BIT_TIMER])
    );

    assign ref_demand = state_next.ref_en;
    pcg_ref_timer #(
        .START_CYC(REF_START_CYC)
    ) u_ref (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(ref_demand),
        .o_ready(ref_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic setup;
        logic access;
        logic deep;
        logic bod_on;
        logic cmp_on;
        setup = i_psel && !i_penable;
        access = i_psel && i_penable;
        deep = deep_sleep(state_reg.sleep);
        // Comparator drops in deep sleep; its reference demand does not
        cmp_on = !state_reg.comp[PCG_BIT_CMP_DIS] && !deep;
        bod_on = (i_brownout_level_fuse != 2'b11);
        state_next = state_reg;
        // Single-cycle access: pready answers in the first access cycle
        state_next.pready = setup;
        state_next.pslverr = 1'b0;
        if (setup && !i_pwrite) begin
            state_next.prdata = 32'h00000000;
            case (i_paddr)
                PCG_ADDR_GATE: state_next.prdata[3:0] = state_reg.gate;
                PCG_ADDR_COMP: state_next.prdata[2:0] = state_reg.comp;
                PCG_ADDR_MCU: state_next.prdata[0] = state_reg.if_dis;
                PCG_ADDR_DIS_LO: state_next.prdata[7:0] = state_reg.dis_lo;
                PCG_ADDR_DIS_HI: state_next.prdata[7:0] = state_reg.dis_hi;
                PCG_ADDR_STATUS: state_next.prdata[7:0] = {ref_ready, state_reg.ref_en,
                    state_reg.adc_ext, state_reg.cmp_en, clk_en};
                PCG_ADDR_SLEEP: state_next.prdata[2:0] = state_reg.sleep;
                default: state_next.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            case (i_paddr)
                PCG_ADDR_GATE: state_next.gate = i_pwdata[3:0];
                PCG_ADDR_COMP: state_next.comp = i_pwdata[2:0];
                PCG_ADDR_MCU: state_next.if_dis = i_pwdata[PCG_BIT_IF_DIS];
                PCG_ADDR_DIS_LO: state_next.dis_lo = i_pwdata[7:0];
                PCG_ADDR_DIS_HI: state_next.dis_hi = i_pwdata[7:0];
                PCG_ADDR_SLEEP: begin
                    if (i_pwdata[2:0] <= PCG_SLP_STANDBY) begin
                        state_next.sleep = i_pwdata[2:0];
                    end else begin
                        state_next.pslverr = 1'b1;
                    end
                end
                default: state_next.pslverr = 1'b1;
            endcase
        end
        if (access) begin
            state_next.pready = 1'b0;
        end
        // ADC ignores sleep; an off-on cycle flags an extended conversion
        state_next.adc_prev = i_adc_enable;
        if (i_adc_enable && !state_reg.adc_prev) begin
            state_next.adc_ext = 1'b1;
        end
        state_next.cmp_en = cmp_on;
        state_next.cmp_mux = cmp_on && state_reg.comp[PCG_BIT_CMP_MUX] &&
            !state_reg.gate[PCG_BIT_CONV];
        state_next.bod_en = bod_on;
        state_next.ref_en = bod_on || i_adc_enable ||
            (!state_reg.comp[PCG_BIT_CMP_DIS] && state_reg.comp[PCG_BIT_CMP_REF]);
        state_next.wdt_run = i_watchdog_enable;
        // Buffers off when io and adc clocks both stop, except wake pins
        for (int i = 0; i < 8; i++) begin
            state_next.ibuf[i] = !state_reg.dis_lo[i] &&
                (!deep || i_wake_pin_mask[i]);
        end
        state_next.if_en = i_interface_enable_fuse && !state_reg.if_dis;
        state_next.main_clk = !deep || (state_reg.sleep == PCG_SLP_STANDBY) ||
            (i_debug_enable_fuse && state_next.if_en);
        state_next.tdo = i_tdo_data;
        state_next.tdo_oe = state_next.if_en && i_tap_shifting;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg <= '0;
            state_reg.gate <= PCG_GATE_RESET;
            state_reg.main_clk <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_prdata = state_reg.prdata;
    assign o_pready = state_reg.pready;
    assign o_pslverr = state_reg.pslverr;
    assign o_timer_clk_en = clk_en[PCG_BIT_TIMER];
    assign o_spi_clk_en = clk_en[PCG_BIT_SPI];
    assign o_usart_clk_en = clk_en[PCG_BIT_USART];
    assign o_adc_clk_en = clk_en[PCG_BIT_CONV];
    // Same enable blocks register access, so a gated block is untouchable
    assign o_periph_access_en = clk_en;
    assign o_adc_extended_conv = state_reg.adc_ext;
    assign o_comparator_en = state_reg.cmp_en;
    assign o_comparator_mux_en = state_reg.cmp_mux;
    assign o_reference_en = state_reg.ref_en;
    assign o_reference_ready = ref_ready;
    assign o_brownout_en = state_reg.bod_en;
    assign o_watchdog_run = state_reg.wdt_run;
    assign o_input_buffer_en = state_reg.ibuf;
    assign o_main_clock_en = state_reg.main_clk;
    assign o_interface_en = state_reg.if_en;
    assign o_tdo = state_reg.tdo;
    assign o_tdo_oe = state_reg.tdo_oe;
endmodule // pcg_top

// [verification/pcg_properties.sv]
// Port checker of the peripheral clock gating block
`timescale 1ns/1ps
module pcg_properties
    import pcg_pkg::*;
#(
    parameter int REF_START_CYC = PCG_REF_START_CYC
) (
    // Clock, reset and bus
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    // Levels in
    input wire logic [1:0] i_brownout_level_fuse,
    input wire logic i_interface_enable_fuse,
    input wire logic i_watchdog_enable,
    input wire logic i_tap_shifting,
    // Levels out
    input wire logic o_timer_clk_en,
    input wire logic o_spi_clk_en,
    input wire logic o_usart_clk_en,
    input wire logic o_adc_clk_en,
    input wire logic o_comparator_mux_en,
    input wire logic o_brownout_en,
    input wire logic o_watchdog_run,
    input wire logic o_interface_en,
    input wire logic o_tdo_oe
);
    logic set_up;
    logic [3:0] gate_wr;
    // Gate bits written at the setup edge, where the write lands
    assign set_up = i_psel && !i_penable && i_pwrite && i_paddr == PCG_ADDR_GATE;
    assign gate_wr = set_up ? i_pwdata[3:0] : 4'h0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_reserved_zero: assert property (
        o_pready && !i_pwrite && i_paddr == PCG_ADDR_GATE |-> o_prdata[31:4] == 28'h0)
        else $error("gate upper bits set");
    a_timer_gate: assert property (
        gate_wr[PCG_BIT_TIMER] |-> ##[1:3] !o_timer_clk_en) else $error("timer clock runs");
    a_spi_gate: assert property (
        gate_wr[PCG_BIT_SPI] |-> ##[1:3] !o_spi_clk_en) else $error("spi clock runs");
    a_usart_gate: assert property (
        gate_wr[PCG_BIT_USART] |-> ##[1:3] !o_usart_clk_en) else $error("usart clock runs");
    a_adc_gate: assert property (
        gate_wr[PCG_BIT_CONV] |-> ##[1:3] (!o_adc_clk_en && !o_comparator_mux_en))
        else $error("adc or mux still on");
    a_brownout_kept: assert property (
        (i_brownout_level_fuse != 2'h3) [*2] |-> o_brownout_en) else $error("detector off");
    a_watchdog_kept: assert property (
        i_watchdog_enable [*2] |-> o_watchdog_run) else $error("watchdog stopped");
    a_interface_off: assert property (
        !i_interface_enable_fuse [*2] |-> !o_interface_en) else $error("interface on");
    a_tdo_released: assert property (
        !i_tap_shifting [*2] |-> !o_tdo_oe) else $error("tdo driven");
    a_reset_clocks: assert property (
        $rose(i_reset_n) |-> o_timer_clk_en && o_spi_clk_en && o_usart_clk_en && o_adc_clk_en)
        else $error("clock gated after reset");
endmodule // pcg_properties

bind pcg_top pcg_properties #(.REF_START_CYC(REF_START_CYC)) u_props (.*);

// [verification/pcg_periph_model.sv]
// Behavioural model of the four gated peripherals
`timescale 1ns/1ps
module pcg_periph_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Gating
    input wire logic [3:0] i_clk_en,
    input wire logic [3:0] i_access_en,
    // Register write and state
    input wire logic i_load,
    input wire logic [7:0] i_load_data,
    output logic [31:0] o_state
);
    // Counts only on clocked edges, so a stopped clock freezes the unit
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (!i_reset_n) begin
                o_state[8*k+:8] <= 8'h00;
            end else if (i_clk_en[k] && i_load && i_access_en[k]) begin
                o_state[8*k+:8] <= i_load_data;
            end else if (i_clk_en[k]) begin
                o_state[8*k+:8] <= o_state[8*k+:8] + 8'h01;
            end
        end
    end
endmodule // pcg_periph_model

// [verification/tb_top.sv]
// Self-checking testbench of the peripheral clock gating block
`timescale 1ns/1ps
module tb_top;
    import pcg_pkg::*;
    localparam int REF_CYC = 4;
    logic i_clk = '0, i_reset_n = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
    logic i_debug_enable_fuse = '0, i_interface_enable_fuse = '1, i_adc_enable = '0;
    logic i_watchdog_enable = '1, i_tap_shifting = '0, i_tdo_data = '0, load = '0;
    logic [1:0] i_brownout_level_fuse = 2'h1;
    logic [7:0] i_wake_pin_mask = 8'h00;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, state, s0, r;
    logic o_pready, o_pslverr, o_timer_clk_en, o_spi_clk_en, o_usart_clk_en, o_adc_clk_en;
    logic o_adc_extended_conv, o_comparator_en, o_comparator_mux_en, o_reference_en;
    logic o_reference_ready, o_brownout_en, o_watchdog_run, o_main_clock_en;
    logic o_interface_en, o_tdo, o_tdo_oe, e;
    logic [3:0] o_periph_access_en, en;
    logic [7:0] o_input_buffer_en, d;
    int errors = 0, n_checks = 0, seed = 62, it, k, m;
    assign en = {o_timer_clk_en, o_spi_clk_en, o_usart_clk_en, o_adc_clk_en};
    always #5 i_clk = ~i_clk;
    pcg_top #(.REF_START_CYC(REF_CYC)) dut_u (.*);
    pcg_periph_model peri_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(en),
        .i_access_en(o_periph_access_en), .i_load(load), .i_load_data(8'hA5), .o_state(state));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    // Waits on pready only; the watchdog ends a hung transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Look between edges, so the values seen are those the next edge samples
        @(negedge i_clk);
        while (o_pready !== 1'b1) @(negedge i_clk);
        rd = o_prdata;
        err = o_pslverr;
        @(posedge i_clk);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic final_report;
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge i_clk);
        errors++;
        final_report;
    end
    initial begin
        i_wake_pin_mask = $random(seed);
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        apb(0, PCG_ADDR_GATE, 0, r, e);
        chk("gate_rst", 32'h0, r);
        chk("clk_rst", 32'hF, {28'h0, en});
        apb(0, 12'hFFC, 0, r, e);
        chk("slverr", 32'h1, {31'h0, e});
        for (it = 0; it < 8; it++) begin
            d = $random(seed);
            if (it == 0) d = 8'hFF;
            i_adc_enable <= 1'b0;
            apb(1, PCG_ADDR_GATE, {24'h0, d}, r, e);
            repeat (3) @(posedge i_clk);
            apb(0, PCG_ADDR_GATE, 0, r, e);
            chk("gate_rd", {28'h0, d[3:0]}, r);
            chk("clk_en", {28'h0, ~d[3:0]}, {28'h0, en});
            chk("access", {28'h0, ~d[3:0]}, {28'h0, o_periph_access_en});
            s0 = state;
            load <= 1'b1;
            @(posedge i_clk);
            load <= 1'b0;
            repeat (3) @(posedge i_clk);
            for (k = 0; k < 4; k++) if (d[k]) chk("frozen", s0[8*k+:8], state[8*k+:8]);
            apb(1, PCG_ADDR_GATE, 0, r, e);
            repeat (3) @(posedge i_clk);
            for (k = 0; k < 4; k++) begin
                if (d[k]) chk("resume", 1, 8'(state[8*k+:8] - s0[8*k+:8] - 8'h1) < 8'h6);
            end
        end
        for (it = 0; it < 12; it++) begin
            m = it % 6;
            i_debug_enable_fuse <= (it >= 6);
            apb(1, PCG_ADDR_SLEEP, m, r, e);
            repeat (3) @(posedge i_clk);
            chk("timer_run", m <= 1, o_timer_clk_en);
            chk("adc_run", m <= 2, o_adc_clk_en);
            chk("cmp_en", m <= 2, o_comparator_en);
            chk("buf_en", m >= 3 ? i_wake_pin_mask : 8'hFF, o_input_buffer_en);
            chk("main_clk", it >= 6 || (m != 3 && m != 4), o_main_clock_en);
        end
        apb(1, PCG_ADDR_SLEEP, 0, r, e);
        d = $random(seed);
        apb(1, PCG_ADDR_DIS_LO, {24'h0, d}, r, e);
        repeat (3) @(posedge i_clk);
        chk("buf_dis", {24'h0, ~d}, {24'h0, o_input_buffer_en});
        apb(1, PCG_ADDR_COMP, 32'h4, r, e);
        repeat (3) @(posedge i_clk);
        chk("mux_on", 1, o_comparator_mux_en);
        apb(1, PCG_ADDR_GATE, 32'h1, r, e);
        repeat (3) @(posedge i_clk);
        chk("mux_off", 0, o_comparator_mux_en);
        apb(1, PCG_ADDR_GATE, 0, r, e);
        i_brownout_level_fuse <= 2'h3;
        apb(1, PCG_ADDR_COMP, 1, r, e);
        repeat (3) @(posedge i_clk);
        chk("ref_off", 0, o_reference_en);
        chk("ext_conv", 0, o_adc_extended_conv);
        i_adc_enable <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("ref_on", 1, o_reference_en);
        chk("ref_wait", 0, o_reference_ready);
        chk("ext_conv", 1, o_adc_extended_conv);
        repeat (REF_CYC + 4) @(posedge i_clk);
        chk("ref_rdy", 1, o_reference_ready);
        i_tap_shifting <= 1'b1;
        i_tdo_data <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("if_on", 1, o_interface_en);
        chk("tdo", 2'h3, {o_tdo_oe, o_tdo});
        apb(1, PCG_ADDR_MCU, 1, r, e);
        repeat (3) @(posedge i_clk);
        chk("if_bit", 0, o_interface_en);
        apb(1, PCG_ADDR_MCU, 0, r, e);
        i_interface_enable_fuse <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("if_fuse", 0, o_interface_en);
        final_report;
    end
endmodule // tb_top
